// ---- verilog/lsde_top.sv ----
// Purpose: Segment LCD scan, drive level selection and expansion link
// Assumes: APB slave, zero wait states; mode inputs synchronous to CLK
// Notes: Pin levels are two-bit codes, see lsde_level_t
//
// Operation
// - RAM bit of segment s, common c is bit 4s+c; expansion remaps pins.
// - Display RAM takes byte and word writes through byte strobes.
// - Once running, RAM is scanned to the pins without software help.
// - Expansion enable turns segment pins 37 to 40 into link pins.
// - Serial data starts at segment 37, or segment 1 when select is 0000.
// - Each pin level follows pixel data combined with alternation.
// - Static: common V1/VSS by alternation; segment same or opposite by data.
// - Third/quarter duty use V2/V3 for unselected; half duty commons mid.
// - Stopped display holds shift, latch and alternation low, data frozen.
// - Standby floats all expansion link pins.
// - Without main clock the display stops unless subclock is chosen.
// - Display runs only when active bit set, not standby, clock present.
// - Standby turns the bias ladder off whatever its power bit.
// - Clearing active halts and turns ladder off, registers kept.
// - Display-data bit 0 blanks all data, also on the link.
// - Clock select bit 3 picks system divider 2..256, else subclock.

`timescale 1ns/1ps

// ==========================================================
// Top module
module lsde_top
  import lsde_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Power mode and subclock
  input wire logic STANDBY,
  input wire logic SUBCLK_MODE,
  input wire logic SUB_TICK,
  // Panel drive
  output logic [2*NCOM-1:0] COMMON_OUTPUT,
  output logic [2*NSEG-1:0] SEGMENT_OUTPUT,
  output logic LADDER_ON,
  // Expansion link
  output logic EXPANSION_LATCH_CLOCK,
  output logic EXPANSION_SHIFT_CLOCK,
  output logic EXPANSION_M,
  output logic EXPANSION_DATA,
  output logic EXPANSION_OE
);

  // ==========================================================
  // State
  typedef struct packed {
    logic ladder_power;
    logic act;
    logic display_data_select;
    logic [3:0] cks;
    logic seg_expand_enable;
    lsde_duty_t duty;
    logic [3:0] sgs;
    logic [NRAMW-1:0][31:0] ram;
    logic [31:0] prdata;
    logic slverr;
    logic [1:0] com_idx;
    logic m;
    lsde_sh_t sh;
    logic [5:0] sh_seg;
    logic cl1;
    logic cl2;
    logic dout;
    logic ladder;
    logic [NCOM-1:0][1:0] com_lvl;
    logic [NSEG-1:0][1:0] seg_lvl;
  } lsde_state_t;

  localparam lsde_state_t ST_RESET = '0;

  lsde_state_t st_q;
  lsde_state_t st_next;

  logic run_w;
  logic tick_w;
  logic [NSEG*NCOM-1:0] ram_flat;
  logic [NCOM-1:0][1:0] com_lvl_w;
  logic [NSEG-1:0][1:0] seg_lvl_w;
  logic setup_w;
  logic access_w;
  logic ram_hit;
  logic [5:0] ram_word;
  logic [2:0] ram_idx;
  logic hit_w;
  logic [31:0] rd_data;
  logic [7:0] lcd_ctl_rd;
  logic [7:0] port_ctl_rd;
  logic [7:0] status_rd;

  // ==========================================================
  // Run and power conditions
  // Runs only when active, out of standby, and a live clock is chosen
  assign run_w = st_q.act && !STANDBY && !(SUBCLK_MODE && st_q.cks[CKS_SYS_BIT]);
  assign ram_flat = st_q.ram;

  // Frame step source selected by clock select field
  lsde_clkgen u_clkgen (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .run(run_w),
    .cks(st_q.cks),
    .sub_tick(SUB_TICK),
    .tick(tick_w)
  );

  // ==========================================================
  // Level selection per pin
  generate
    for (genvar c = 0; c < NCOM; c++) begin : g_com
      lsde_level u_lvl (
        .duty(st_q.duty),
        .is_com(1'b1),
        .m(st_q.m),
        .bit_on(st_q.com_idx == 2'(c) && 2'(c) <= st_q.duty),
        .level(com_lvl_w[c])
      );
    end
    for (genvar s = 0; s < NSEG; s++) begin : g_seg
      // Blank data, unused drivers and link pins carry data 0
      lsde_level u_lvl (
        .duty(st_q.duty),
        .is_com(1'b0),
        .m(st_q.m),
        .bit_on(st_q.display_data_select && st_q.sgs != SGS_EXT_ONLY
                && !(st_q.seg_expand_enable && s >= int'(EXP_FIRST_SEG))
                && ram_flat[s*NCOM + int'(st_q.com_idx)]),
        .level(seg_lvl_w[s])
      );
    end
  endgenerate

  // ==========================================================
  // APB decode and read data
  assign setup_w = PSEL && !PENABLE;
  assign access_w = PSEL && PENABLE;
  assign ram_word = PADDR[7:2] - RAM_WORD_BASE;
  assign ram_idx = ram_word[2:0];
  assign ram_hit = PADDR >= ADDR_RAM_BASE && PADDR <= ADDR_RAM_LAST && PADDR[1:0] == 2'h0;
  assign hit_w = ram_hit || PADDR == ADDR_PORT_CTL || PADDR == ADDR_LCD_CTL
                 || PADDR == ADDR_STATUS;

  // Register images, reserved control bit reads as one
  always_comb begin
    lcd_ctl_rd = 8'h00;
    lcd_ctl_rd[CTL_RSVD] = LCD_CTL_RESET[CTL_RSVD];
    lcd_ctl_rd[CTL_PSW] = st_q.ladder_power;
    lcd_ctl_rd[CTL_ACT] = st_q.act;
    lcd_ctl_rd[CTL_DISPLAY_DATA_SELECT] = st_q.display_data_select;
    lcd_ctl_rd[CTL_CKS_LSB +: 4] = st_q.cks;
    port_ctl_rd = 8'h00;
    port_ctl_rd[PC_SGX] = st_q.seg_expand_enable;
    port_ctl_rd[PC_DTS_LSB +: 2] = st_q.duty;
    port_ctl_rd[PC_SGS_LSB +: 4] = st_q.sgs;
    status_rd = 8'h00;
    status_rd[ST_RUN] = run_w;
    status_rd[ST_LADDER] = st_q.ladder;
    status_rd[ST_M] = st_q.m;
    status_rd[ST_COM_LSB +: 2] = st_q.com_idx;
  end

  // Read data multiplexer, unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (ram_hit) begin
      rd_data = st_q.ram[ram_idx];
    end else if (PADDR == ADDR_PORT_CTL) begin
      rd_data = {24'h00_0000, port_ctl_rd};
    end else if (PADDR == ADDR_LCD_CTL) begin
      rd_data = {24'h00_0000, lcd_ctl_rd};
    end else if (PADDR == ADDR_STATUS) begin
      rd_data = {24'h00_0000, status_rd};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_q;

    // Read data and error flag captured in the setup cycle
    if (setup_w) begin
      st_next.prdata = rd_data;
      st_next.slverr = !hit_w;
    end

    // Register writes in the access cycle; registers survive stop
    if (access_w && PWRITE && hit_w) begin
      if (ram_hit) begin
        for (int b = 0; b < 4; b++) begin
          if (PSTRB[b]) begin
            st_next.ram[ram_idx][8*b +: 8] = PWDATA[8*b +: 8];
          end
        end
      end else if (PADDR == ADDR_PORT_CTL && PSTRB[0]) begin
        st_next.seg_expand_enable = PWDATA[PC_SGX];
        st_next.duty = lsde_duty_t'(PWDATA[PC_DTS_LSB +: 2]);
        st_next.sgs = PWDATA[PC_SGS_LSB +: 4];
      end else if (PADDR == ADDR_LCD_CTL && PSTRB[0]) begin
        st_next.ladder_power = PWDATA[CTL_PSW];
        st_next.act = PWDATA[CTL_ACT];
        st_next.display_data_select = PWDATA[CTL_DISPLAY_DATA_SELECT];
        st_next.cks = PWDATA[CTL_CKS_LSB +: 4];
      end
    end

    // Ladder only with power bit, active bit and out of standby
    st_next.ladder = st_q.ladder_power && st_q.act && !STANDBY;

    // Expansion shift sequence, one segment per two cycles
    unique case (st_q.sh)
      SH_IDLE: begin
        st_next.cl1 = 1'b0;
        st_next.cl2 = 1'b0;
      end
      SH_LOW: begin
        st_next.cl2 = 1'b0;
        st_next.dout = st_q.display_data_select && ram_flat[{st_q.sh_seg, st_q.com_idx}];
        st_next.sh = SH_HIGH;
      end
      SH_HIGH: begin
        st_next.cl2 = 1'b1;
        if (st_q.sh_seg == EXP_LAST_SEG) begin
          st_next.sh = SH_LATCH;
        end else begin
          st_next.sh_seg = st_q.sh_seg + 6'h01;
          st_next.sh = SH_LOW;
        end
      end
      SH_LATCH: begin
        st_next.cl2 = 1'b0;
        st_next.cl1 = 1'b1;
        st_next.sh = SH_IDLE;
      end
    endcase

    // Common step on each frame clock step; a new step restarts the link
    if (run_w && tick_w) begin
      if (st_q.com_idx == st_q.duty) begin
        st_next.com_idx = 2'h0;
        st_next.m = !st_q.m;
      end else begin
        st_next.com_idx = st_q.com_idx + 2'h1;
      end
      if (st_q.seg_expand_enable) begin
        st_next.sh = SH_LOW;
        st_next.sh_seg = (st_q.sgs == SGS_EXT_ONLY) ? 6'h00 : EXP_FIRST_SEG;
      end
    end

    // Stopped display: link quiet, data line holds its level
    if (!run_w) begin
      st_next.cl1 = 1'b0;
      st_next.cl2 = 1'b0;
      st_next.m = 1'b0;
      st_next.sh = SH_IDLE;
      st_next.com_idx = 2'h0;
    end

    // Registered pin levels, all at VSS while stopped
    for (int c = 0; c < NCOM; c++) begin
      st_next.com_lvl[c] = run_w ? com_lvl_w[c] : LV_VSS;
    end
    for (int s = 0; s < NSEG; s++) begin
      st_next.seg_lvl[s] = run_w ? seg_lvl_w[s] : LV_VSS;
    end
  end

  // State register, frozen while CE is low
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= ST_RESET;
    end else if (CE) begin
      st_q <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign PREADY = CE;
  assign PRDATA = st_q.prdata;
  assign PSLVERR = access_w && st_q.slverr;
  assign COMMON_OUTPUT = st_q.com_lvl;
  assign SEGMENT_OUTPUT = st_q.seg_lvl;
  assign LADDER_ON = st_q.ladder;
  assign EXPANSION_LATCH_CLOCK = st_q.cl1;
  assign EXPANSION_SHIFT_CLOCK = st_q.cl2;
  assign EXPANSION_M = st_q.m;
  assign EXPANSION_DATA = st_q.dout;
  // Link pins driven only with expansion on and out of standby
  assign EXPANSION_OE = st_q.seg_expand_enable && !STANDBY;

  // ==========================================================
  // Assertions
  property p_stop_quiet;
    @(posedge CLK) disable iff (SRST)
      (CE && !run_w) |=> (!EXPANSION_SHIFT_CLOCK && !EXPANSION_LATCH_CLOCK && !EXPANSION_M);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("Link clocks or alternation not low while stopped");

  property p_data_frozen;
    @(posedge CLK) disable iff (SRST)
      (CE && !run_w && st_q.sh == SH_IDLE) |=> $stable(EXPANSION_DATA);
  endproperty
  a_data_frozen: assert property (p_data_frozen)
    else $error("Link data moved while stopped");

  property p_standby_float;
    @(posedge CLK) disable iff (SRST)
      STANDBY |-> !EXPANSION_OE;
  endproperty
  a_standby_float: assert property (p_standby_float)
    else $error("Link pins driven in standby");

  property p_ladder_off;
    @(posedge CLK) disable iff (SRST)
      (CE && (!st_q.act || STANDBY)) |=> !LADDER_ON;
  endproperty
  a_ladder_off: assert property (p_ladder_off)
    else $error("Bias ladder on while inactive or in standby");

  property p_frame_flip;
    @(posedge CLK) disable iff (SRST)
      (CE && run_w && tick_w && st_q.com_idx == st_q.duty) |=> (EXPANSION_M != $past(EXPANSION_M));
  endproperty
  a_frame_flip: assert property (p_frame_flip)
    else $error("Alternation did not toggle at frame end");

  property p_sub_stop;
    @(posedge CLK) disable iff (SRST)
      (CE && SUBCLK_MODE && st_q.cks[CKS_SYS_BIT]) |=> (COMMON_OUTPUT == '0 && !EXPANSION_M);
  endproperty
  a_sub_stop: assert property (p_sub_stop)
    else $error("Display runs on an absent main clock");

  property p_byte_write;
    @(posedge CLK) disable iff (SRST)
      (CE && access_w && PWRITE && PADDR == ADDR_RAM_BASE && PSTRB == 4'h1)
        |=> (st_q.ram[0][31:8] == $past(st_q.ram[0][31:8]) && st_q.ram[0][7:0] == $past(PWDATA[7:0]));
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("Byte write touched other lanes or missed its own");

  property p_static_com;
    @(posedge CLK) disable iff (SRST)
      (CE && run_w && st_q.duty == DUTY_STATIC)
        |=> (COMMON_OUTPUT[1:0] == ($past(st_q.m) ? LV_VSS : LV_V1));
  endproperty
  a_static_com: assert property (p_static_com)
    else $error("Static common level wrong");

  property p_link_start;
    @(posedge CLK) disable iff (SRST)
      (CE && run_w && tick_w && st_q.seg_expand_enable && st_q.sgs != SGS_EXT_ONLY)
        |=> (st_q.sh == SH_LOW && st_q.sh_seg == EXP_FIRST_SEG);
  endproperty
  a_link_start: assert property (p_link_start)
    else $error("Link shift did not start at segment 37");

endmodule

// ---- include/lsde_pkg.sv ----
// Purpose: Shared constants and types of the segment LCD drive and expansion block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Levels are coded on two bits per output pin

// ==========================================================
// Package
package lsde_pkg;

  // Sizes of the panel and of the display RAM
  localparam int NSEG = 40;
  localparam int NCOM = 4;
  localparam int NRAMW = 5;

  // Register byte addresses
  localparam logic [7:0] ADDR_PORT_CTL = 8'h00;
  localparam logic [7:0] ADDR_LCD_CTL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h10;
  localparam logic [7:0] ADDR_RAM_LAST = 8'h20;
  localparam logic [5:0] RAM_WORD_BASE = 6'h04;

  // lcd_control fields; bit 7 is reserved and reads 1
  localparam logic [7:0] LCD_CTL_RESET = 8'h80;
  localparam int CTL_RSVD = 7;
  localparam int CTL_PSW = 6;
  localparam int CTL_ACT = 5;
  localparam int CTL_DISPLAY_DATA_SELECT = 4;
  localparam int CTL_CKS_LSB = 0;
  localparam int CKS_SYS_BIT = 3;
  localparam int CKS_HALF_BIT = 1;

  // lcd_port_control fields
  localparam int PC_SGX = 7;
  localparam int PC_DTS_LSB = 4;
  localparam int PC_SGS_LSB = 0;

  // status fields
  localparam int ST_RUN = 0;
  localparam int ST_LADDER = 1;
  localparam int ST_M = 2;
  localparam int ST_COM_LSB = 4;

  // Segment 37 and segment 40, counted from zero
  localparam logic [5:0] EXP_FIRST_SEG = 6'h24;
  localparam logic [5:0] EXP_LAST_SEG = 6'h27;
  localparam logic [3:0] SGS_EXT_ONLY = 4'h0;

  // Duty codes double as index of the last common
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'h0, DUTY_HALF = 2'h1, DUTY_THIRD = 2'h2, DUTY_QUARTER = 2'h3
  } lsde_duty_t;

  // Drive level codes
  typedef enum logic [1:0] {
    LV_VSS = 2'h0, LV_V1 = 2'h1, LV_V2 = 2'h2, LV_V3 = 2'h3
  } lsde_level_t;

  // Expansion shift sequencer
  typedef enum logic [1:0] {
    SH_IDLE = 2'h0, SH_LOW = 2'h1, SH_HIGH = 2'h2, SH_LATCH = 2'h3
  } lsde_sh_t;

endpackage

// ---- verilog/lsde_level.sv ----
// Purpose: Drive level of one common or segment pin
// Assumes: Purely combinational, fed from registered state
// Notes: For a common, bit_on means the common is selected

`timescale 1ns/1ps

// ==========================================================
// Level mapper
module lsde_level
  import lsde_pkg::*;
(
  // Selection
  input wire lsde_duty_t duty,
  input wire logic is_com,
  input wire logic m,
  input wire logic bit_on,
  // Result
  output lsde_level_t level
);

  // Level table per duty, alternation and data
  always_comb begin
    level = LV_VSS;
    if (bit_on) begin
      level = (m ^ !is_com) ? LV_VSS : LV_V1;
    end else if (duty == DUTY_STATIC || (duty == DUTY_HALF && !is_com)) begin
      level = m ? LV_VSS : LV_V1;
    end else if (duty == DUTY_HALF) begin
      level = LV_V2; // Mid level, V2 tied to V3
    end else if (is_com) begin
      level = m ? LV_V2 : LV_V3;
    end else begin
      level = m ? LV_V3 : LV_V2;
    end
  end

endmodule

// ---- verilog/lsde_clkgen.sv ----
// Purpose: Frame clock step generator from system clock or subclock
// Assumes: sub_tick is a one-cycle pulse per subclock period
// Notes: Stops and clears while run is low

`timescale 1ns/1ps

// ==========================================================
// Step generator
module lsde_clkgen
  import lsde_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic [3:0] cks,
  input wire logic sub_tick,
  // Step pulse
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic half;
    logic tick;
  } lsde_gen_t;

  lsde_gen_t q;
  lsde_gen_t n;
  logic [7:0] mask;

  // Divider, 2 up to 256 on system clock, 1 or 2 on subclock
  always_comb begin
    n = q;
    n.tick = 1'b0;
    mask = 8'hFF >> (3'h7 - cks[2:0]);
    if (!run) begin
      n.cnt = 8'h00;
      n.half = 1'b0;
    end else if (cks[CKS_SYS_BIT]) begin
      n.cnt = q.cnt + 8'h01;
      n.tick = &(q.cnt | ~mask);
    end else if (sub_tick) begin
      n.half = !q.half;
      n.tick = cks[CKS_HALF_BIT] ? q.half : 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule

// ---- dv/lsde_segdrv_model.sv ----
// Purpose: Behavioural external segment driver on the expansion link
// Assumes: Link lines are sampled on the system clock
// Notes: Reports each latched line together with its bit count

`timescale 1ns/1ps

// ==========================================================
// Segment driver model
module lsde_segdrv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link
  input wire logic oe,
  input wire logic shift,
  input wire logic latch,
  input wire logic data,
  // Latched line
  output logic [39:0] line,
  output logic [5:0] nbits,
  output logic got
);
  logic [39:0] sr;
  logic [5:0] cnt;
  logic shift_d;
  logic latch_d;

  // Shift on a rising shift clock, take the line on a rising latch
  always @(posedge clk) begin
    shift_d <= shift;
    latch_d <= latch;
    got <= 1'b0;
    // Register restarts empty so a short line carries zeros above its bits
    if (srst || !oe) begin
      cnt <= 6'h00;
      sr <= '0;
    end else if (latch && !latch_d) begin
      line <= sr;
      nbits <= cnt;
      got <= 1'b1;
      cnt <= 6'h00;
      sr <= '0;
    end else if (shift && !shift_d) begin
      sr <= {sr[38:0], data};
      cnt <= cnt + 6'h01;
    end
  end
endmodule

// ---- dv/lsde_tb_top.sv ----
// Purpose: Self-checking bench of the segment LCD drive and expansion block
// Assumes: Zero-wait APB slave, levels as two-bit codes
// Notes: Expected results queue up; monitors compare as results appear

`timescale 1ns/1ps

// ==========================================================
// Bench top
module lsde_tb_top;
  import lsde_pkg::*;
  typedef struct packed {
    logic w;
    logic err;
    logic [31:0] m;
    logic [31:0] d;
  } lsde_apb_exp_t;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic CE = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'h0;
  logic STANDBY = 1'b0;
  logic SUBCLK_MODE = 1'b0;
  logic SUB_TICK = 1'b0;
  logic [2:0] sdiv = 3'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, LADDER_ON, EXPANSION_OE, EXPANSION_M, EXPANSION_DATA;
  logic EXPANSION_LATCH_CLOCK, EXPANSION_SHIFT_CLOCK, got, mprev, pm, ds;
  logic [7:0] COMMON_OUTPUT, pcom;
  logic [79:0] SEGMENT_OUTPUT, pseg;
  logic [39:0] line, e;
  logic [5:0] nbits;
  logic [159:0] ram_sh;
  logic [45:0] lx;
  lsde_apb_exp_t ax;
  lsde_apb_exp_t aq[$];
  logic [45:0] lq[$];
  int pq[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int last_e = 0;
  logic lvl_on = 1'b0;
  logic display_data_select = 1'b1;
  lsde_duty_t duty = DUTY_STATIC;

  always #2.5 CLK = ~CLK;

  lsde_top dut (.CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY(STANDBY), .SUBCLK_MODE(SUBCLK_MODE),
    .SUB_TICK(SUB_TICK), .COMMON_OUTPUT(COMMON_OUTPUT), .SEGMENT_OUTPUT(SEGMENT_OUTPUT),
    .LADDER_ON(LADDER_ON), .EXPANSION_LATCH_CLOCK(EXPANSION_LATCH_CLOCK),
    .EXPANSION_SHIFT_CLOCK(EXPANSION_SHIFT_CLOCK), .EXPANSION_M(EXPANSION_M),
    .EXPANSION_DATA(EXPANSION_DATA), .EXPANSION_OE(EXPANSION_OE));

  lsde_segdrv_model partner (.clk(CLK), .srst(SRST), .oe(EXPANSION_OE),
    .shift(EXPANSION_SHIFT_CLOCK), .latch(EXPANSION_LATCH_CLOCK), .data(EXPANSION_DATA),
    .line(line), .nbits(nbits), .got(got));

  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [79:0] ex, input logic [79:0] g);
    samples_checked++;
    if (g !== ex) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; the access phase may see a random clock-enable stall
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic err, input logic [31:0] m, input logic [31:0] ex);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    aq.push_back(lsde_apb_exp_t'{w, err, m, ex});
    @(posedge CLK);
    PENABLE <= 1'b1;
    CE <= ($urandom_range(3) != 0);
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      CE <= 1'b1;
      @(posedge CLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, 1'b0, 32'h0, 32'h0);
  endtask

  task rd(input logic [7:0] a, input logic err, input logic [31:0] m, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, 4'h0, err, m, ex);
  endtask

  // Display RAM write that also updates the shadow copy per byte lane
  task ram(input int i, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) ram_sh[32*i+8*b +: 8] = d[8*b +: 8];
    apb(1'b1, 8'h10 + 8'(4*i), d, s, 1'b0, 32'h0, 32'h0);
  endtask

  task wait_m(input int n);
    int e0;
    repeat (n) begin
      e0 = last_e;
      repeat (3000) if (last_e == e0) @(posedge CLK);
    end
  endtask

  task automatic lv_chk;
    logic [1:0] sel, uns;
    logic [79:0] es;
    int c, nsel;
    sel = pm ? LV_VSS : LV_V1;
    uns = (duty >= DUTY_THIRD && !pm) ? LV_V3 : LV_V2;
    c = 0;
    nsel = 0;
    for (int i = 0; i <= int'(duty); i++) begin
      if (COMMON_OUTPUT[2*i +: 2] === sel) begin
        c = i;
        nsel++;
      end else chk("com_unselected", uns, COMMON_OUTPUT[2*i +: 2]);
    end
    chk("com_selected_count", 1, nsel);
    for (int s = 0; s < NSEG; s++)
      es[2*s +: 2] = (display_data_select & ram_sh[4*s+c]) ? (pm ? LV_V1 : LV_VSS) :
          ((duty >= DUTY_THIRD) ? (pm ? LV_V3 : LV_V2) : sel);
    chk("segment_levels", es, SEGMENT_OUTPUT);
  endtask

  // ==========================================================
  // Monitors and stimulus helpers
  always @(posedge CLK) begin
    sdiv <= sdiv + 3'h1;
    SUB_TICK <= (sdiv == 3'h7);
  end

  always @(posedge CLK) begin
    cyc++;
    if (EXPANSION_M !== mprev) begin
      if (pq.size() > 0) chk("m_period", 80'(pq.pop_front()), 80'(cyc - last_e));
      last_e = cyc;
    end
    mprev = EXPANSION_M;
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
      ax = aq.pop_front();
      chk("pslverr", ax.err, PSLVERR);
      if (!ax.w) chk("prdata", ax.d, PRDATA & ax.m);
    end
    if (got === 1'b1 && lq.size() > 0) begin
      lx = lq.pop_front();
      chk("link_count", lx[45:40], nbits);
      chk("link_bits", lx[39:0], line);
    end
  end

  always @(negedge CLK) begin
    if (lvl_on && COMMON_OUTPUT === pcom && SEGMENT_OUTPUT === pseg && EXPANSION_M === pm)
      lv_chk();
    pcom = COMMON_OUTPUT;
    pseg = SEGMENT_OUTPUT;
    pm = EXPANSION_M;
  end

  initial begin
    repeat (80000) @(posedge CLK);
    n_fail++;
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(66719));
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    rd(ADDR_LCD_CTL, 1'b0, 32'hFFFFFFFF, 32'h80);
    rd(ADDR_STATUS, 1'b0, 32'hFFFFFFFF, 32'h0);
    rd(8'h0C, 1'b1, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 8'hFC, 32'hFFFFFFFF, 4'hF, 1'b1, 32'h0, 32'h0);
    chk("ladder_reset", 0, LADDER_ON);
    $display("test reset done");
    for (int i = 0; i < NRAMW; i++) ram(i, $urandom, 4'hF);
    ram(1, $urandom, 4'b0100);
    ram(3, $urandom, 4'b0011);
    ram(0, $urandom, 4'b0001);
    rd(8'h10, 1'b0, 32'hFFFFFFFF, ram_sh[31:0]);
    rd(8'h14, 1'b0, 32'hFFFFFFFF, ram_sh[63:32]);
    rd(8'h1C, 1'b0, 32'hFFFFFFFF, ram_sh[127:96]);
    $display("test ram writes done");
    wr(ADDR_LCD_CTL, 32'h79);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_PORT_CTL, {26'h0, d[1:0], 4'hF});
      duty = lsde_duty_t'(d);
      repeat (8) @(posedge CLK);
      lvl_on = 1'b1;
      repeat (300) @(posedge CLK);
      lvl_on = 1'b0;
    end
    wr(ADDR_LCD_CTL, 32'h69);
    display_data_select = 1'b0;
    repeat (8) @(posedge CLK);
    lvl_on = 1'b1;
    repeat (200) @(posedge CLK);
    lvl_on = 1'b0;
    $display("test levels done");
    wr(ADDR_PORT_CTL, 32'h0F);
    for (int k = 8; k < 16; k++) begin
      wr(ADDR_LCD_CTL, 32'h70 | k);
      wait_m(3);
      @(negedge CLK);
      pq.push_back(2 << (k - 8));
      wait_m(1);
    end
    for (int k = 0; k < 3; k += 2) begin
      wr(ADDR_LCD_CTL, 32'h70 | k);
      @(posedge CLK);
      SUBCLK_MODE <= 1'b1;
      wait_m(3);
      @(negedge CLK);
      pq.push_back(8 << (k / 2));
      wait_m(1);
    end
    wr(ADDR_LCD_CTL, 32'h78);
    repeat (4) @(posedge CLK);
    rd(ADDR_STATUS, 1'b0, 32'h1, 32'h0);
    @(posedge CLK);
    SUBCLK_MODE <= 1'b0;
    $display("test frame clock done");
    wr(ADDR_LCD_CTL, 32'h7F);
    wr(ADDR_PORT_CTL, 32'h8F);
    repeat (2) @(posedge CLK);
    chk("link_enable", 1, EXPANSION_OE);
    for (int t = 0; t < 3; t++) begin
      if (t == 1) wr(ADDR_PORT_CTL, 32'h80);
      if (t == 2) wr(ADDR_LCD_CTL, 32'h6F);
      e = 40'h0;
      for (int i = 0; i < 40; i++) if (t == 1) e[39-i] = ram_sh[4*i];
      for (int i = 0; i < 4; i++) if (t == 0) e[3-i] = ram_sh[4*(36+i)];
      repeat (700) @(posedge CLK);
      @(negedge CLK);
      lq.push_back({(t == 0) ? 6'd4 : 6'd40, e});
      lq.push_back({(t == 0) ? 6'd4 : 6'd40, e});
      repeat (1200) @(posedge CLK);
      chk("link_lines_left", 0, lq.size());
    end
    $display("test expansion link done");
    wr(ADDR_LCD_CTL, 32'h5F);
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    ds = EXPANSION_DATA;
    repeat (60) begin
      @(negedge CLK);
      chk("stopped_link", {3'b000, ds}, {EXPANSION_SHIFT_CLOCK, EXPANSION_LATCH_CLOCK,
        EXPANSION_M, EXPANSION_DATA});
    end
    chk("ladder_inactive", 0, LADDER_ON);
    rd(ADDR_LCD_CTL, 1'b0, 32'hFF, 32'hDF);
    $display("test stop done");
    wr(ADDR_LCD_CTL, 32'h7F);
    repeat (4) @(posedge CLK);
    chk("ladder_on", 1, LADDER_ON);
    STANDBY <= 1'b1;
    repeat (4) @(posedge CLK);
    chk("standby_float", 0, EXPANSION_OE);
    chk("standby_ladder", 0, LADDER_ON);
    rd(ADDR_STATUS, 1'b0, 32'h3, 32'h0);
    @(posedge CLK);
    STANDBY <= 1'b0;
    $display("test standby done");
    final_report;
  end
endmodule
